// ### logic/rdai_defines.svh
`ifndef RDAI_DEFINES_SVH
`define RDAI_DEFINES_SVH

// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define RDAI_IDX_CFG   6'h10
`define RDAI_IDX_EN    6'h12
`define RDAI_IDX_STS   6'h13
`define RDAI_IDX_CTL   6'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define RDAI_BIT_IDLE  4
`define RDAI_BIT_AIS   5
`define RDAI_CFG_AIS   7
`define RDAI_CFG_IDLE  5
`define RDAI_CTL_AUTO  0
`define RDAI_IRQ_MASK  8'h30

// ----------------------------------------
// reset values and answers
// ----------------------------------------
`define RDAI_EN_RST    8'h00
`define RDAI_STS_RST   8'h00
`define RDAI_RESP_OK   2'h0
`define RDAI_RESP_ERR  2'h2

// ----------------------------------------
// persistence: 63 frames, counted 0..62
// ----------------------------------------
`define RDAI_PERSIST_LAST 6'h3E
`define RDAI_CNT_ONE      6'h01
`define RDAI_CNT_ZERO     6'h00

`endif

// ### logic/rdai_persist.sv
`timescale 1ns/1ps
`default_nettype none
`include "rdai_defines.svh"

module rdai_persist
  import rdai_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // frame stream
  input  wire logic frame_tick,
  input  wire logic pattern_seen,
  // condition
  output logic      cond_state,
  output logic      cond_change
);

  rdai_persist_type r_reg;
  rdai_persist_type r_next;

  // ----------------------------------------
  // consecutive-frame persistence
  // ----------------------------------------
  always_comb begin
    r_next      = r_reg;
    cond_change = 1'b0;
    if (frame_tick) begin
      if (pattern_seen != r_reg.state) begin
        if (r_reg.cnt == `RDAI_PERSIST_LAST) begin
          r_next.state = ~r_reg.state;
          r_next.cnt   = `RDAI_CNT_ZERO;
          cond_change  = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + `RDAI_CNT_ONE;
        end
      end else begin
        // an agreeing frame breaks the run
        r_next.cnt = `RDAI_CNT_ZERO;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cond_state = r_reg.state;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_declare;
    @(posedge clk) disable iff (!rst_n)
    frame_tick && pattern_seen && !r_reg.state && r_reg.cnt == `RDAI_PERSIST_LAST |=> r_reg.state;
  endproperty
  a_declare: assert property (p_declare) else $error("condition not declared");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    frame_tick && !pattern_seen && r_reg.state && r_reg.cnt == `RDAI_PERSIST_LAST |=> !r_reg.state;
  endproperty
  a_clear: assert property (p_clear) else $error("condition not cleared");

  property p_persist;
    @(posedge clk) disable iff (!rst_n)
    $changed(r_reg.state) |-> $past(r_reg.cnt) == `RDAI_PERSIST_LAST && $past(frame_tick);
  endproperty
  a_persist: assert property (p_persist) else $error("state flipped early");

  c_flip: cover property (@(posedge clk) disable iff (!rst_n) $rose(r_reg.state));

endmodule // rdai_persist

`default_nettype wire

// ### logic/rdai_pkg.sv
`default_nettype none

package rdai_pkg;

  typedef enum logic [2:0] {
    RDAI_SEL_CFG,
    RDAI_SEL_EN,
    RDAI_SEL_STS,
    RDAI_SEL_CTL,
    RDAI_SEL_NONE
  } rdai_reg_type;

  typedef struct packed {
    logic       state;
    logic [5:0] cnt;
  } rdai_persist_type;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] sts;
    logic       ctl;
    logic       aw_full;
    logic [5:0] aw_idx;
    logic       w_full;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic       irq_n;
    logic       far;
  } rdai_top_type;

endpackage

`default_nettype wire

// ### logic/rdai_top.sv
// ----------------------------------------
// Overview of operation
// - declare AIS after 63 consecutive frames carrying the AIS pattern
// - clear declared AIS after 63 frames without the AIS pattern
// - enabled AIS interrupt fires on both declaration and clearance
// - enable register bit 5 gates the AIS change interrupt
// - enable bit 1 allows its source, 0 masks it
// - enabled AIS change drives the interrupt output low
// - enabled AIS change sets status bit 5
// - config/status bit 7 shows live AIS state
// - auto far-fail on alarm sends far-end failure while AIS declared
// - enabled idle interrupt fires on idle start and stop
// - declare idle after 63 frames carrying the idle pattern
// - clear idle after 63 frames without the idle pattern
// - enable register bit 4 gates the idle change interrupt
// - enabled idle change drives the interrupt output low
// - enabled idle change sets status bit 4
// - config/status bit 5 shows live idle state
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "rdai_defines.svh"

module rdai_top
  import rdai_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // receive frame stream, same clock
  input  wire logic        frame_tick,
  input  wire logic        frame_ais_seen,
  input  wire logic        frame_idle_seen,
  // alarm outputs
  output logic             irq_n,
  output logic             far_fail_send
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // alarm detectors: 0 idle, 1 ais
  // ----------------------------------------
  logic [1:0] pat_seen;
  logic [1:0] cond_st;
  logic [1:0] cond_chg;
  logic       rx_alarm_signal_state;
  logic       rx_idle_state;

  assign pat_seen = {frame_ais_seen, frame_idle_seen};

  // live states keep running whatever the enables say
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_det
      rdai_persist u_persist (
        .clk          (clk),
        .rst_n        (rst_n),
        .frame_tick   (frame_tick),
        .pattern_seen (pat_seen[g]),
        .cond_state   (cond_st[g]),
        .cond_change  (cond_chg[g])
      );
    end
  endgenerate

  assign rx_idle_state         = cond_st[0];
  assign rx_alarm_signal_state = cond_st[1];

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function automatic rdai_reg_type rdai_decode(input logic [5:0] idx);
    rdai_reg_type sel;
    case (idx)
      `RDAI_IDX_CFG: sel = RDAI_SEL_CFG;
      `RDAI_IDX_EN:  sel = RDAI_SEL_EN;
      `RDAI_IDX_STS: sel = RDAI_SEL_STS;
      `RDAI_IDX_CTL: sel = RDAI_SEL_CTL;
      default:       sel = RDAI_SEL_NONE;
    endcase
    return sel;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  rdai_top_type r_reg;
  rdai_top_type r_next;
  rdai_reg_type wr_sel;
  rdai_reg_type rd_sel;
  logic         hs_aw;
  logic         hs_w;
  logic         hs_ar;
  logic         rd_clear;

  assign s_axi_awready = !r_reg.aw_full && !r_reg.bvalid;
  assign s_axi_wready  = !r_reg.w_full && !r_reg.bvalid;
  assign s_axi_arready = !r_reg.rvalid;

  assign hs_aw = s_axi_awvalid && s_axi_awready;
  assign hs_w  = s_axi_wvalid && s_axi_wready;
  assign hs_ar = s_axi_arvalid && s_axi_arready;

  always_comb begin
    r_next   = r_reg;
    wr_sel   = RDAI_SEL_NONE;
    rd_sel   = RDAI_SEL_NONE;
    rd_clear = 1'b0;

    // write path: address and data in either order
    if (hs_aw) begin
      r_next.aw_full = 1'b1;
      r_next.aw_idx  = s_axi_awaddr[7:2];
    end
    if (hs_w) begin
      r_next.w_full  = 1'b1;
      r_next.w_data  = s_axi_wdata[7:0];
      r_next.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_next.aw_full && r_next.w_full) begin
      wr_sel         = rdai_decode(r_next.aw_idx);
      r_next.aw_full = 1'b0;
      r_next.w_full  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = `RDAI_RESP_OK;
      case (wr_sel)
        RDAI_SEL_EN: begin
          if (r_next.w_lane0) begin
            r_next.en = r_next.w_data;
          end
        end
        RDAI_SEL_CTL: begin
          if (r_next.w_lane0) begin
            r_next.ctl = r_next.w_data[`RDAI_CTL_AUTO];
          end
        end
        // read-only or unmapped: refused
        default: r_next.bresp = `RDAI_RESP_ERR;
      endcase
    end

    // read path
    if (s_axi_rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (hs_ar) begin
      rd_sel        = rdai_decode(s_axi_araddr[7:2]);
      r_next.rvalid = 1'b1;
      r_next.rresp  = `RDAI_RESP_OK;
      r_next.rdata  = 8'h00;
      case (rd_sel)
        RDAI_SEL_CFG: begin
          r_next.rdata[`RDAI_CFG_AIS]  = rx_alarm_signal_state;
          r_next.rdata[`RDAI_CFG_IDLE] = rx_idle_state;
        end
        RDAI_SEL_EN:  r_next.rdata = r_reg.en;
        RDAI_SEL_STS: begin
          r_next.rdata = r_reg.sts;
          rd_clear     = 1'b1;
        end
        RDAI_SEL_CTL: r_next.rdata[`RDAI_CTL_AUTO] = r_reg.ctl;
        default:      r_next.rresp = `RDAI_RESP_ERR;
      endcase
    end

    // clear on read first, so a same-cycle event still lands
    if (rd_clear) begin
      r_next.sts = `RDAI_STS_RST;
    end
    if (cond_chg[0] && r_reg.en[`RDAI_BIT_IDLE]) begin
      r_next.sts[`RDAI_BIT_IDLE] = 1'b1;
    end
    if (cond_chg[1] && r_reg.en[`RDAI_BIT_AIS]) begin
      r_next.sts[`RDAI_BIT_AIS] = 1'b1;
    end

    // low while any enabled bit pends
    r_next.irq_n = ~|(r_next.sts & r_next.en & `RDAI_IRQ_MASK);

    // follows the new live state so it starts and stops with it
    r_next.far = r_next.ctl && (cond_st[1] ^ cond_chg[1]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg       <= '0;
      r_reg.en    <= `RDAI_EN_RST;
      r_reg.sts   <= `RDAI_STS_RST;
      r_reg.irq_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rresp   = r_reg.rresp;
  assign s_axi_rdata   = {24'h000000, r_reg.rdata};
  assign irq_n         = r_reg.irq_n;
  assign far_fail_send = r_reg.far;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ais_status;
    @(posedge clk) disable iff (!rst_n)
    $changed(rx_alarm_signal_state) && $past(r_reg.en[`RDAI_BIT_AIS]) |->
      r_reg.sts[`RDAI_BIT_AIS] && (!irq_n || !r_reg.en[`RDAI_BIT_AIS]);
  endproperty
  a_ais_status: assert property (p_ais_status) else $error("ais change not flagged");

  property p_ais_irq;
    @(posedge clk) disable iff (!rst_n)
    $rose(r_reg.sts[`RDAI_BIT_AIS]) && r_reg.en[`RDAI_BIT_AIS] |-> !irq_n;
  endproperty
  a_ais_irq: assert property (p_ais_irq) else $error("irq not low on ais");

  property p_idle_status;
    @(posedge clk) disable iff (!rst_n)
    $changed(rx_idle_state) && $past(r_reg.en[`RDAI_BIT_IDLE]) |-> r_reg.sts[`RDAI_BIT_IDLE];
  endproperty
  a_idle_status: assert property (p_idle_status) else $error("idle change not flagged");

  property p_idle_irq;
    @(posedge clk) disable iff (!rst_n)
    $rose(r_reg.sts[`RDAI_BIT_IDLE]) && r_reg.en[`RDAI_BIT_IDLE] |-> !irq_n;
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("irq not low on idle");

  property p_mask;
    @(posedge clk) disable iff (!rst_n)
    $rose(r_reg.sts[`RDAI_BIT_AIS]) || $rose(r_reg.sts[`RDAI_BIT_IDLE]) |->
      ($past(r_reg.en[`RDAI_BIT_AIS]) || !$rose(r_reg.sts[`RDAI_BIT_AIS]))
      && ($past(r_reg.en[`RDAI_BIT_IDLE]) || !$rose(r_reg.sts[`RDAI_BIT_IDLE]));
  endproperty
  a_mask: assert property (p_mask) else $error("masked source set status");

  property p_cfg_read;
    @(posedge clk) disable iff (!rst_n)
    hs_ar && s_axi_araddr[7:2] == `RDAI_IDX_CFG |=>
      s_axi_rvalid && r_reg.rdata[`RDAI_CFG_AIS] == $past(rx_alarm_signal_state)
      && r_reg.rdata[`RDAI_CFG_IDLE] == $past(rx_idle_state);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("live state read wrong");

  property p_sts_clear;
    @(posedge clk) disable iff (!rst_n)
    hs_ar && s_axi_araddr[7:2] == `RDAI_IDX_STS && cond_chg == 2'h0 |=>
      r_reg.rdata == $past(r_reg.sts) && r_reg.sts == `RDAI_STS_RST && irq_n;
  endproperty
  a_sts_clear: assert property (p_sts_clear) else $error("status not cleared on read");

  property p_far_on;
    @(posedge clk) disable iff (!rst_n)
    r_reg.ctl && $rose(rx_alarm_signal_state) |-> far_fail_send;
  endproperty
  a_far_on: assert property (p_far_on) else $error("far fail not sent");

  property p_far_off;
    @(posedge clk) disable iff (!rst_n)
    !rx_alarm_signal_state |-> !far_fail_send;
  endproperty
  a_far_off: assert property (p_far_off) else $error("far fail without ais");

  property p_far_hold;
    @(posedge clk) disable iff (!rst_n)
    r_reg.ctl && rx_alarm_signal_state |-> far_fail_send;
  endproperty
  a_far_hold: assert property (p_far_hold) else $error("far fail dropped during ais");

  property p_irq_source;
    @(posedge clk) disable iff (!rst_n)
    !irq_n |-> (r_reg.sts & r_reg.en & `RDAI_IRQ_MASK) != `RDAI_STS_RST;
  endproperty
  a_irq_source: assert property (p_irq_source) else $error("irq low, none pending");

  property p_irq_masked;
    @(posedge clk) disable iff (!rst_n)
    (r_reg.sts & r_reg.en & `RDAI_IRQ_MASK) == `RDAI_STS_RST |-> irq_n;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq held low");

  property p_ais_masked;
    @(posedge clk) disable iff (!rst_n)
    !$past(r_reg.en[`RDAI_BIT_AIS]) && !$past(r_reg.sts[`RDAI_BIT_AIS]) |->
      !r_reg.sts[`RDAI_BIT_AIS];
  endproperty
  a_ais_masked: assert property (p_ais_masked) else $error("masked ais status set");

  property p_idle_masked;
    @(posedge clk) disable iff (!rst_n)
    !$past(r_reg.en[`RDAI_BIT_IDLE]) && !$past(r_reg.sts[`RDAI_BIT_IDLE]) |->
      !r_reg.sts[`RDAI_BIT_IDLE];
  endproperty
  a_idle_masked: assert property (p_idle_masked) else $error("masked idle status set");

  c_ais_irq: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(irq_n) && r_reg.sts[`RDAI_BIT_AIS]);
  c_idle_irq: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(r_reg.sts[`RDAI_BIT_IDLE]));
  c_sts_read: cover property (@(posedge clk) disable iff (!rst_n)
    hs_ar && s_axi_araddr[7:2] == `RDAI_IDX_STS && r_reg.sts != `RDAI_STS_RST);
  c_far: cover property (@(posedge clk) disable iff (!rst_n) $rose(far_fail_send));

endmodule // rdai_top

`default_nettype wire

// ### verif/rdai_frame_src.sv
`timescale 1ns/1ps
`default_nettype none

// ------
// frame stream source
// ------
module rdai_frame_src (
  // clock
  input  wire logic clk,
  // frame stream
  output var logic  frame_tick,
  output var logic  frame_ais_seen,
  output var logic  frame_idle_seen
);
  initial begin
    frame_tick      = 1'b0;
    frame_ais_seen  = 1'b1;
    frame_idle_seen = 1'b1;
  end

  // gap idle cycles between ticks; pattern lines flip off-tick
  task automatic send(input int n, input logic ais, input logic idle, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      frame_tick      <= 1'b1;
      frame_ais_seen  <= ais;
      frame_idle_seen <= idle;
      repeat (gap) begin
        @(posedge clk);
        frame_tick      <= 1'b0;
        frame_ais_seen  <= ~ais;
        frame_idle_seen <= ~idle;
      end
    end
    @(posedge clk);
    frame_tick      <= 1'b0;
    frame_ais_seen  <= ~ais;
    frame_idle_seen <= ~idle;
  endtask
endmodule // rdai_frame_src

`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, br;
  logic        frame_tick, frame_ais_seen, frame_idle_seen, irq_n, far_fail_send;
  int          errors = 0;
  int          n_checks = 0;
  // address, write data, write resp, read data, read resp
  localparam logic [27:0] ROWS [6] = '{
    {8'h48, 8'hFF, 2'h0, 8'hFF, 2'h0}, {8'h48, 8'h30, 2'h0, 8'h30, 2'h0},
    {8'h40, 8'hFF, 2'h2, 8'h00, 2'h0}, {8'h4C, 8'hFF, 2'h2, 8'h00, 2'h0},
    {8'h50, 8'h01, 2'h0, 8'h01, 2'h0}, {8'h44, 8'hFF, 2'h2, 8'h00, 2'h2}};

  always #4 clk = ~clk;

  rdai_top i_dut (.clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .frame_tick,
    .frame_ais_seen, .frame_idle_seen, .irq_n, .far_fail_send);
  rdai_frame_src i_src (.clk, .frame_tick, .frame_ais_seen, .frame_idle_seen);

  // ------
  // compare and bus tasks
  // ------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h00000000, got}, {31'h00000000, exp});
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= 4'h1;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge clk);
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(a, d, br);
    chk_word({30'h00000000, br}, 32'h00000000);
  endtask

  // read and compare data and response in one go
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    @(posedge clk);
    while (s_axi_arready !== 1'b1) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(posedge clk);
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    chk_word(s_axi_rdata, {24'h000000, e});
    chk_word({30'h00000000, s_axi_rresp}, {30'h00000000, er});
    s_axi_rready <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------
  // tests
  // ------
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      axi_wr(ROWS[i][27:20], ROWS[i][19:12], br);
      chk_word({30'h00000000, br}, {30'h00000000, ROWS[i][11:10]});
      rd_chk(ROWS[i][27:20], ROWS[i][9:2], ROWS[i][1:0]);
    end
    $display("register table done");
    // reset in mid-run clears enable and control
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(8'h48, 8'h00, 2'h0);
    rd_chk(8'h50, 8'h00, 2'h0);
    $display("reset done");
    // declaration needs the full run, back to back
    wr(8'h48, 8'h30);
    wr(8'h50, 8'h01);
    i_src.send(62, 1'b1, 1'b0, 0);
    #1 chk_bit(irq_n, 1'b1);
    rd_chk(8'h40, 8'h00, 2'h0);
    i_src.send(1, 1'b1, 1'b0, 0);
    #1 chk_bit(irq_n, 1'b0);
    chk_bit(far_fail_send, 1'b1);
    rd_chk(8'h40, 8'h80, 2'h0);
    rd_chk(8'h4C, 8'h20, 2'h0);
    #1 chk_bit(irq_n, 1'b1);
    rd_chk(8'h4C, 8'h00, 2'h0);
    $display("alarm declare done");
    // an agreeing frame restarts the clearance run
    i_src.send(40, 1'b0, 1'b0, 2);
    i_src.send(1, 1'b1, 1'b0, 2);
    i_src.send(62, 1'b0, 1'b0, 2);
    rd_chk(8'h40, 8'h80, 2'h0);
    i_src.send(1, 1'b0, 1'b0, 2);
    #1 chk_bit(irq_n, 1'b0);
    chk_bit(far_fail_send, 1'b0);
    rd_chk(8'h40, 8'h00, 2'h0);
    rd_chk(8'h4C, 8'h20, 2'h0);
    $display("alarm clear done");
    // alarm masked, auto far-fail off: live flag only
    wr(8'h50, 8'h00);
    wr(8'h48, 8'h10);
    i_src.send(63, 1'b1, 1'b0, 0);
    #1 chk_bit(irq_n, 1'b1);
    chk_bit(far_fail_send, 1'b0);
    rd_chk(8'h40, 8'h80, 2'h0);
    rd_chk(8'h4C, 8'h00, 2'h0);
    // idle masked on declare, enabled on clear
    wr(8'h48, 8'h20);
    i_src.send(63, 1'b1, 1'b1, 0);
    #1 chk_bit(irq_n, 1'b1);
    rd_chk(8'h40, 8'hA0, 2'h0);
    rd_chk(8'h4C, 8'h00, 2'h0);
    wr(8'h48, 8'h30);
    i_src.send(63, 1'b1, 1'b0, 1);
    #1 chk_bit(irq_n, 1'b0);
    rd_chk(8'h40, 8'h80, 2'h0);
    rd_chk(8'h4C, 8'h10, 2'h0);
    i_src.send(63, 1'b1, 1'b1, 0);
    rd_chk(8'h4C, 8'h10, 2'h0);
    $display("idle done");
    tally_and_finish();
  end

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire
